// >>> core/lss_sync.v
// Summary of operation
// - continuous mode 0x2 checks phase on every alignment edge, subclass 1 only
// - continuous mode needs no arming; first edge after enable is checked
// - alignment edges are ignored while a clock rotation is underway
// - every pulse is checked, rotation only when error exceeds tolerance
// - arm bit self-clears on an alignment edge; harmless in continuous mode
// - mode 0x9 aligns on first armed edge, later edges only measure
// - current phase error field reads zero after alignment, updates per edge
// - low or high side flag set when error exceeds window tolerance
// - on alignment, last error and side flags copied to snapshot registers
// - host picks mode, window, then enable; arm afterwards in one-shot
// - busy high while processing; lock and window-limit updated per check
// - sticky rotate and trip bits, cleared only by clear-sticky write
// - mode field decodes 0x1 one-shot, 0x2 continuous, 0x9 monitor
// - window codes 0..3 give half, one, two, three dac clocks tolerance
// - lock, rotate, trip, window-limit raise per-converter interrupt events
// - subclass 0 and 1 supported, subclass 2 is not
// - subclass 0 needs no sysref; converters stay aligned to each other
// - each link gets a local lmfc delayed modulo multiframe from aligned lmfc
// - receive buffer delay programmable 0 to 10 processing clocks
// - one-shot mode checks first armed edge, rotates only beyond window
// - sysref active high, sampled on rising device clock edge
// - each converter owns an lmfc; aligned to pclk or sysref by subclass
`timescale 1ns/100ps
`default_nettype none
`include "lss_defs.vh"

module lss_sync #(
  parameter LMFC_K    = 32,
  parameter FRAME_CYC = 2,
  parameter PCLK_CYC  = 4
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        reset_n_i,
  // register port
  input  wire [11:0] reg_addr_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  input  wire [7:0]  reg_wdata_i,
  output reg  [7:0]  reg_rdata_o,
  // alignment input
  input  wire        sysref_i,
  // lmfc, buffer release and interrupt
  output wire [1:0]  lmfc_o,
  output wire [1:0]  lmfc_rx_o,
  output wire [1:0]  rbd_release_o,
  output wire        irq_o
);

  // widths fixed here so products and remainders stay in range
  localparam          PW        = 12;
  localparam [31:0]   LMFC_CYC  = LMFC_K * FRAME_CYC;
  localparam [31:0]   K_32      = LMFC_K;
  localparam [31:0]   FRAME_32  = FRAME_CYC;
  localparam [31:0]   PCLK_32   = PCLK_CYC;
  localparam [PW-1:0] LMFC_W    = LMFC_CYC[PW-1:0];
  localparam [PW-1:0] LMFC_LAST = LMFC_W - {{(PW-1){1'b0}}, 1'b1};
  localparam [PW-1:0] LMFC_HALF = {1'b0, LMFC_W[PW-1:1]};
  localparam [PW-1:0] PCLK_W    = PCLK_32[PW-1:0];
  localparam [PW-1:0] PCLK_LAST = PCLK_W - {{(PW-1){1'b0}}, 1'b1};
  localparam [PW-1:0] FRAME_W   = FRAME_32[PW-1:0];
  localparam [7:0]    K_W       = K_32[7:0];
  localparam ST_IDLE = 1'b0;
  localparam ST_ROT  = 1'b1;

  // ********************************
  // decode helper
  // ********************************
  function hit;
    input [11:0] a;
    input [11:0] ref_a;
    begin
      hit = (a == ref_a);
    end
  endfunction

  // side flags: bit7 just past the boundary, bit6 before it
  function [1:0] side_code;
    input over;
    input late;
    begin
      side_code = over ? {late, !late} : 2'b00;
    end
  endfunction

  // ********************************
  // configuration registers
  // ********************************
  reg  [7:0] page_ff;
  reg  [7:0] irq_en_ff [0:1];
  reg  [2:0] window_ff;
  reg  [3:0] align_mode_sel_ff;
  reg        align_en_ff;
  reg        align_arm_ff;
  reg  [2:0] dev_sc_ff;
  reg  [2:0] link_sc_ff;
  reg  [7:0] lmfc_del_ff [0:1];
  reg  [7:0] lmfc_var_ff [0:1];
  wire       wr_ctrl = reg_wr_i && hit(reg_addr_i, `LSS_ADR_CTRL);
  wire       clear_sticky_flags = wr_ctrl && reg_wdata_i[`LSS_CTRL_CLR];

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      page_ff      <= `LSS_PAGE_RST;
      irq_en_ff[0] <= 8'h00;
      irq_en_ff[1] <= 8'h00;
      window_ff    <= 3'h0;
      dev_sc_ff    <= 3'h0;
      link_sc_ff   <= 3'h0;
      lmfc_del_ff[0] <= 8'h00;
      lmfc_del_ff[1] <= 8'h00;
      lmfc_var_ff[0] <= 8'h00;
      lmfc_var_ff[1] <= 8'h00;
    end else if (reg_wr_i) begin
      if (hit(reg_addr_i, `LSS_ADR_PAGE))   page_ff      <= reg_wdata_i;
      if (hit(reg_addr_i, `LSS_ADR_IRQEN0)) irq_en_ff[0] <= reg_wdata_i;
      if (hit(reg_addr_i, `LSS_ADR_IRQEN1)) irq_en_ff[1] <= reg_wdata_i;
      if (hit(reg_addr_i, `LSS_ADR_WINDOW)) window_ff    <= reg_wdata_i[2:0];
      if (hit(reg_addr_i, `LSS_ADR_DEV_SC)) dev_sc_ff    <= reg_wdata_i[2:0];
      if (hit(reg_addr_i, `LSS_ADR_LINK_SC)) link_sc_ff  <= reg_wdata_i[7:5];
      if (hit(reg_addr_i, `LSS_ADR_DEL0))   lmfc_del_ff[0] <= reg_wdata_i;
      if (hit(reg_addr_i, `LSS_ADR_DEL1))   lmfc_del_ff[1] <= reg_wdata_i;
      if (hit(reg_addr_i, `LSS_ADR_VAR0))   lmfc_var_ff[0] <= reg_wdata_i;
      if (hit(reg_addr_i, `LSS_ADR_VAR1))   lmfc_var_ff[1] <= reg_wdata_i;
    end
  end

  // subclass 2 is not supported and falls back to the internal edge
  wire sc_one = (dev_sc_ff == `LSS_SC_ONE);

  // ********************************
  // alignment edge sources
  // ********************************
  reg  sysref_s1_ff;
  reg  sysref_s2_ff;
  reg  sysref_s3_ff;
  reg  [PW-1:0] pclk_cnt_ff;
  wire pclk_tick = (pclk_cnt_ff == PCLK_LAST);

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      sysref_s1_ff <= 1'b0;
      sysref_s2_ff <= 1'b0;
      sysref_s3_ff <= 1'b0;
      pclk_cnt_ff  <= {PW{1'b0}};
    end else begin
      sysref_s1_ff <= sysref_i;
      sysref_s2_ff <= sysref_s1_ff;
      sysref_s3_ff <= sysref_s2_ff;
      pclk_cnt_ff  <= pclk_tick ? {PW{1'b0}} : pclk_cnt_ff + 1'b1;
    end
  end

  // subclass 0 aligns to the processing clock, no sysref pin needed
  wire align_edge = sc_one ? (sysref_s2_ff & ~sysref_s3_ff) : pclk_tick;

  // ********************************
  // sync machine
  // ********************************
  reg        state_ff;
  reg  [3:0] rot_cnt_ff;
  reg        monitor_ff;
  wire [PW-1:0] pos0;
  wire [PW-1:0] pos1;
  wire [PW-1:0] meas_pos = page_ff[0] ? pos0 : pos1;
  wire       is_oneshot = (align_mode_sel_ff == `LSS_MODE_ONESHOT);
  wire       is_cont    = (align_mode_sel_ff == `LSS_MODE_CONT);
  wire       is_mon     = (align_mode_sel_ff == `LSS_MODE_MONITOR);
  // edges during a rotation are dropped, not queued
  wire       edge_ok = align_edge && align_en_ff && (state_ff == ST_IDLE);
  wire       do_check = edge_ok && ((is_cont && sc_one) ||
                                    ((is_oneshot || is_mon) && align_arm_ff) ||
                                    (is_mon && monitor_ff));
  wire       late_side = (meas_pos <= LMFC_HALF);
  wire [PW-1:0] err_full = late_side ? meas_pos : (LMFC_W - meas_pos);
  wire [3:0] phase_error_value = (err_full > 12'h00F) ? 4'hF : err_full[3:0];
  wire       beyond = (window_ff == 3'h0) ? (phase_error_value != 4'h0)
                                          : ({1'b0, phase_error_value} > {2'b00, window_ff});
  wire       first_mon = is_mon && align_arm_ff;
  wire       rotate = do_check && (first_mon ? (phase_error_value != 4'h0)
                                             : (beyond && !is_mon));

  reg  [3:0] cur_err_ff;
  reg  [1:0] side_ff;
  reg  [3:0] snap_err_ff;
  reg  [1:0] snap_flg_ff;
  reg        lock_ff;
  reg        wlim_ff;
  reg        rotation_done_flag_ff;
  reg        phase_checked_flag_ff;

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_ff     <= ST_IDLE;
      rot_cnt_ff   <= 4'h0;
      monitor_ff   <= 1'b0;
      align_mode_sel_ff <= 4'h0;
      align_en_ff  <= 1'b0;
      align_arm_ff <= 1'b0;
      cur_err_ff   <= 4'h0;
      side_ff      <= 2'b00;
      snap_err_ff  <= 4'h0;
      snap_flg_ff  <= 2'b00;
      lock_ff      <= 1'b0;
      wlim_ff      <= 1'b0;
      rotation_done_flag_ff <= 1'b0;
      phase_checked_flag_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        align_mode_sel_ff <= reg_wdata_i[3:0];
        align_en_ff       <= reg_wdata_i[`LSS_CTRL_EN];
        if (!reg_wdata_i[`LSS_CTRL_EN]) monitor_ff <= 1'b0;
      end
      // arm clears on any edge taken while enabled and not rotating; a same-cycle write re-arms
      if (wr_ctrl && reg_wdata_i[`LSS_CTRL_ARM])
        align_arm_ff <= 1'b1;
      else if (edge_ok)
        align_arm_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (rotate) begin
            state_ff   <= ST_ROT;
            rot_cnt_ff <= `LSS_ROT_CYC;
          end
        end
        ST_ROT: begin
          rot_cnt_ff <= rot_cnt_ff - 4'h1;
          if (rot_cnt_ff == 4'h1) state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
      if (do_check) begin
        if (first_mon) monitor_ff <= 1'b1;
        lock_ff    <= !beyond;
        wlim_ff    <= beyond;
        cur_err_ff <= rotate ? 4'h0 : phase_error_value;
        side_ff    <= side_code(beyond, late_side);
        if (rotate) begin
          snap_err_ff <= phase_error_value;
          snap_flg_ff <= side_code(beyond, late_side);
        end
      end
      // set wins over a same-cycle clear
      if (rotate) rotation_done_flag_ff <= 1'b1;
      else if (clear_sticky_flags) rotation_done_flag_ff <= 1'b0;
      if (do_check) phase_checked_flag_ff <= 1'b1;
      else if (clear_sticky_flags) phase_checked_flag_ff <= 1'b0;
    end
  end

  wire busy = (state_ff == ST_ROT) || (align_en_ff && align_arm_ff);

  // ********************************
  // per-converter lmfc and interrupt status
  // ********************************
  wire [PW*2-1:0] pos_all;
  wire [7:0]      irq_st0;
  wire [7:0]      irq_st1;
  wire [1:0]      irq_hit;
  assign pos0 = pos_all[PW-1:0];
  assign pos1 = pos_all[PW*2-1:PW];

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : gen_conv
      reg  [PW-1:0] pos_ff;
      reg  [3:0]    irq_st_ff;
      wire [3:0]    ev = {do_check & !beyond, rotate,
                          do_check & beyond, do_check};
      wire          paged = page_ff[c];
      wire          w1c = reg_wr_i && hit(reg_addr_i, c ? `LSS_ADR_IRQST1 : `LSS_ADR_IRQST0);
      always @(posedge clk_i) begin
        if (!reset_n_i) begin
          pos_ff    <= {PW{1'b0}};
          irq_st_ff <= 4'h0;
        end else begin
          // the edge cycle is phase zero, so rotation lands on one
          if (rotate && paged)
            pos_ff <= {{(PW-1){1'b0}}, 1'b1};
          else
            pos_ff <= (pos_ff == LMFC_LAST) ? {PW{1'b0}} : pos_ff + 1'b1;
          irq_st_ff <= (irq_st_ff & ~(w1c ? reg_wdata_i[3:0] : 4'h0)) |
                       (paged ? ev : 4'h0);
        end
      end
      assign pos_all[PW*c+PW-1:PW*c] = pos_ff;
      assign lmfc_o[c]  = (pos_ff == {PW{1'b0}});
      assign irq_hit[c] = |(irq_st_ff & irq_en_ff[c][3:0]);
      if (c == 0) begin : gen_s0
        assign irq_st0 = {4'h0, irq_st_ff};
      end else begin : gen_s1
        assign irq_st1 = {4'h0, irq_st_ff};
      end
    end
  endgenerate

  assign irq_o = |irq_hit;

  // ********************************
  // per-link local lmfc and buffer delay
  // ********************************
  genvar l;
  generate
    for (l = 0; l < 2; l = l + 1) begin : gen_link
      reg  [PW-1:0] rbd_cnt_ff;
      reg           rx_ff;
      reg           rel_ff;
      // both links count from converter 0's aligned phase
      wire [7:0]    del_mod = lmfc_del_ff[l] % K_W;
      wire [PW-1:0] rx_pos  = {{(PW-8){1'b0}}, del_mod} * FRAME_W;
      wire [7:0]    var_cap = (lmfc_var_ff[l] > `LSS_RBD_MAX) ? `LSS_RBD_MAX
                                                             : lmfc_var_ff[l];
      wire          rx_edge = (pos0 == rx_pos);
      always @(posedge clk_i) begin
        if (!reset_n_i) begin
          rbd_cnt_ff <= {PW{1'b0}};
          rx_ff      <= 1'b0;
          rel_ff     <= 1'b0;
        end else begin
          rx_ff  <= rx_edge;
          rel_ff <= 1'b0;
          if (rx_edge) begin
            if (var_cap == 8'h00) rel_ff <= 1'b1;
            rbd_cnt_ff <= {{(PW-8){1'b0}}, var_cap} * PCLK_W;
          end else if (rbd_cnt_ff != {PW{1'b0}}) begin
            rbd_cnt_ff <= rbd_cnt_ff - 1'b1;
            if (rbd_cnt_ff == {{(PW-1){1'b0}}, 1'b1}) rel_ff <= 1'b1;
          end
        end
      end
      assign lmfc_rx_o[l]     = rx_ff;
      assign rbd_release_o[l] = rel_ff;
    end
  endgenerate

  // ********************************
  // register readback
  // ********************************
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `LSS_ADR_PAGE:     reg_rdata_o <= page_ff;
        `LSS_ADR_IRQEN0:   reg_rdata_o <= irq_en_ff[0];
        `LSS_ADR_IRQEN1:   reg_rdata_o <= irq_en_ff[1];
        `LSS_ADR_IRQST0:   reg_rdata_o <= irq_st0;
        `LSS_ADR_IRQST1:   reg_rdata_o <= irq_st1;
        `LSS_ADR_WINDOW:   reg_rdata_o <= {5'h00, window_ff};
        `LSS_ADR_SNAP_ERR: reg_rdata_o <= {4'h0, snap_err_ff};
        `LSS_ADR_SNAP_FLG: reg_rdata_o <= {snap_flg_ff, 6'h00};
        `LSS_ADR_CTRL:     reg_rdata_o <= {align_en_ff, align_arm_ff, 2'b00, align_mode_sel_ff};
        `LSS_ADR_STATUS:   reg_rdata_o <= {busy, 3'b000, lock_ff, rotation_done_flag_ff,
                                           wlim_ff, phase_checked_flag_ff};
        `LSS_ADR_CUR_ERR:  reg_rdata_o <= {4'h0, cur_err_ff};
        `LSS_ADR_SIDE:     reg_rdata_o <= {side_ff, 6'h00};
        `LSS_ADR_DEV_SC:   reg_rdata_o <= {5'h00, dev_sc_ff};
        `LSS_ADR_DEL0:     reg_rdata_o <= lmfc_del_ff[0];
        `LSS_ADR_DEL1:     reg_rdata_o <= lmfc_del_ff[1];
        `LSS_ADR_VAR0:     reg_rdata_o <= lmfc_var_ff[0];
        `LSS_ADR_VAR1:     reg_rdata_o <= lmfc_var_ff[1];
        `LSS_ADR_LINK_SC:  reg_rdata_o <= {link_sc_ff, 5'h00};
        default:           reg_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule // lss_sync

`default_nettype wire

// >>> core/lss_defs.vh
`ifndef LSS_DEFS_VH
`define LSS_DEFS_VH

// ********************************
// register offsets
// ********************************
`define LSS_ADR_PAGE       12'h008
`define LSS_ADR_IRQEN0     12'h021
`define LSS_ADR_IRQEN1     12'h022
`define LSS_ADR_IRQST0     12'h025
`define LSS_ADR_IRQST1     12'h026
`define LSS_ADR_WINDOW     12'h034
`define LSS_ADR_SNAP_ERR   12'h038
`define LSS_ADR_SNAP_FLG   12'h039
`define LSS_ADR_CTRL       12'h03A
`define LSS_ADR_STATUS     12'h03B
`define LSS_ADR_CUR_ERR    12'h03C
`define LSS_ADR_SIDE       12'h03D
`define LSS_ADR_DEV_SC     12'h301
`define LSS_ADR_DEL0       12'h304
`define LSS_ADR_DEL1       12'h305
`define LSS_ADR_VAR0       12'h306
`define LSS_ADR_VAR1       12'h307
`define LSS_ADR_LINK_SC    12'h458

// ********************************
// field positions
// ********************************
`define LSS_CTRL_EN        7
`define LSS_CTRL_ARM       6
`define LSS_CTRL_CLR       5
`define LSS_ST_BUSY        7
`define LSS_ST_LOCK        3
`define LSS_ST_ROT         2
`define LSS_ST_WLIM        1
`define LSS_ST_TRIP        0
`define LSS_SIDE_HIGH      7
`define LSS_SIDE_LOW       6

// ********************************
// codes and reset values
// ********************************
`define LSS_MODE_ONESHOT   4'h1
`define LSS_MODE_CONT      4'h2
`define LSS_MODE_MONITOR   4'h9
`define LSS_SC_ONE         3'h1
`define LSS_PAGE_RST       8'h03
`define LSS_RBD_MAX        8'h0A
`define LSS_ROT_CYC        4'h8

`endif

// >>> tb/lss_sysref_src.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// sysref source
// ****************
module lss_sysref_src #(
  parameter int HIGH_CYC = 2
) (
  // clock and launch request
  input  wire logic clk_i,
  input  wire logic fire_i,
  // alignment edge
  output wire logic sysref_o
);
  int left_ff = 0;

  // active high, moves just after a rising clock edge
  assign sysref_o = (left_ff != 0);

  // one pulse per request, driven low between pulses
  always @(posedge clk_i) begin
    left_ff <= fire_i ? HIGH_CYC : ((left_ff == 0) ? 0 : left_ff - 1);
  end
endmodule // lss_sysref_src
`default_nettype wire

// >>> tb/lss_sync_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// port checker
// ****************
module lss_sync_checker #(
  parameter int PCLK_CYC = 4
) (
  // clock and register port
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic [7:0]  reg_rdata_o,
  // alignment side
  input wire logic        sysref_i,
  input wire logic [1:0]  lmfc_o,
  input wire logic [1:0]  lmfc_rx_o,
  input wire logic [1:0]  rbd_release_o,
  input wire logic        irq_o
);
  logic [7:0] var_ff;
  logic [7:0] cnt_ff;
  logic [1:0] ien_ff;
  logic       hit;
  logic       rel_ok;
  int         lo;

  // release lands var*pclk after the rx edge; zero shares the rx pulse
  assign lo = var_ff * PCLK_CYC;
  assign rel_ok = (var_ff == 8'h00) ? lmfc_rx_o[0] : (cnt_ff >= lo && cnt_ff <= lo + 1);

  always @* begin
    case (reg_addr_i)
      12'h008, 12'h021, 12'h022, 12'h025, 12'h026, 12'h034, 12'h038, 12'h039,
      12'h03A, 12'h03B, 12'h03C, 12'h03D, 12'h301, 12'h304, 12'h305, 12'h306,
      12'h307, 12'h458: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      var_ff <= 8'h00;
      ien_ff <= 2'h0;
      cnt_ff <= 8'hFF;
    end else begin
      if (reg_wr_i && reg_addr_i == 12'h306) begin
        var_ff <= (reg_wdata_i > 8'h0A) ? 8'h0A : reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == 12'h021) begin
        ien_ff[0] <= |reg_wdata_i[3:0];
      end
      if (reg_wr_i && reg_addr_i == 12'h022) begin
        ien_ff[1] <= |reg_wdata_i[3:0];
      end
      cnt_ff <= lmfc_rx_o[0] ? 8'h01 : ((cnt_ff == 8'hFF) ? 8'hFF : cnt_ff + 8'h01);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_rdata_stands: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed with no read");
  chk_unmapped_zero: assert property (reg_rd_i && !hit |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_page_read: assert property (reg_rd_i && reg_addr_i == 12'h008 |=> reg_rdata_o[1:0] == 2'h3)
    else $error("page register lost both converters");
  chk_lmfc_single: assert property (lmfc_o[0] |=> !lmfc_o[0])
    else $error("lmfc pulse longer than one cycle");
  chk_conv_aligned: assert property (lmfc_o[0] == lmfc_o[1])
    else $error("converter lmfcs out of step");
  chk_rx_single: assert property (lmfc_rx_o[0] |=> !lmfc_rx_o[0])
    else $error("rx lmfc pulse longer than one cycle");
  chk_release_delay: assert property (rbd_release_o[0] |-> rel_ok)
    else $error("buffer release at wrong distance from rx lmfc");
  chk_irq_masked: assert property (ien_ff == 2'h0 |-> !irq_o)
    else $error("interrupt raised with all enables off");

  cov_rx: cover property (lmfc_rx_o[0]);
  cov_release: cover property (rbd_release_o[0]);
  cov_irq: cover property ($rose(irq_o));
endmodule // lss_sync_checker

bind lss_sync lss_sync_checker #(.PCLK_CYC(PCLK_CYC)) u_lss_sync_checker (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .sysref_i(sysref_i), .lmfc_o(lmfc_o), .lmfc_rx_o(lmfc_rx_o),
  .rbd_release_o(rbd_release_o), .irq_o(irq_o)
);
`default_nettype wire

// >>> tb/lss_sync_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// bench top
// ****************
module lss_sync_tb_top;
  localparam int P = 64;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        fire = 1'b0;
  logic        pend = 1'b0;
  logic        bey;
  logic [7:0]  rv;
  logic [7:0]  sd;
  logic [7:0]  eq[$];
  logic [7:0]  mq[$];
  wire  [7:0]  reg_rdata_o;
  wire  [1:0]  lmfc_o;
  wire  [1:0]  lmfc_rx_o;
  wire  [1:0]  rbd_release_o;
  wire         irq_o;
  wire         sysref_i;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          anc;
  int          t;
  int          s;
  int          e;
  int          w;
  int          k;

  lss_sync #(.LMFC_K(32), .FRAME_CYC(2), .PCLK_CYC(4)) u_lss_sync (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .sysref_i(sysref_i), .lmfc_o(lmfc_o), .lmfc_rx_o(lmfc_rx_o),
    .rbd_release_o(rbd_release_o), .irq_o(irq_o)
  );
  lss_sysref_src u_lss_sysref_src (.clk_i(clk_i), .fire_i(fire), .sysref_o(sysref_i));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) cyc <= cyc + 1;

  // old read data is still on the port in the active region of the edge
  always @(posedge clk_i) begin
    if (pend) cmp8(reg_rdata_o, eq.pop_front(), mq.pop_front());
    pend = reg_rd_i;
  end

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    if (m != 8'h00) begin
      num_checks++;
      if ((got & m) !== (exp & m)) begin
        num_errors++;
        $display("Error at %0t: read %h, expected %h mask %h", $time, got, exp, m);
      end
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: irq %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic [7:0] m);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    eq.push_back(x);
    mq.push_back(m);
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    rv = reg_rdata_o;
  endtask

  // second pulse lands while the first one is still rotating
  task automatic fire_at(input int at, input int n);
    int j;
    while (cyc < at) @(negedge clk_i);
    for (j = 0; j < n; j++) begin
      fire = 1'b1;
      @(negedge clk_i);
      fire = 1'b0;
      repeat (3) @(negedge clk_i);
    end
    repeat (2) @(negedge clk_i);
  endtask

  task automatic idle();
    int n;
    for (n = 0; n < 40; n++) begin
      rd(12'h03B, 8'h00, 8'h00);
      if (rv[7] === 1'b0) return;
    end
    num_errors++;
    $display("Error at %0t: busy never cleared", $time);
    summarize();
  endtask

  task automatic summarize();
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'hD72F16AA));
    repeat (20) @(negedge clk_i);
    reset_n_i = 1'b1;
    rd(12'h008, 8'h03, 8'hFF);
    rd(12'h03A, 8'h00, 8'hFF);
    rd(12'h03B, 8'h00, 8'hFF);
    rd(12'h123, 8'h00, 8'hFF);
    $display("reset values test done");
    wr(12'h008, 8'h03);
    wr(12'h301, 8'h01);
    wr(12'h458, 8'h20);
    wr(12'h306, 8'h03);
    wr(12'h307, 8'h03);
    rd(12'h306, 8'h03, 8'hFF);
    wr(12'h034, 8'($urandom_range(0, 3)));
    wr(12'h03A, 8'h01);
    wr(12'h03A, 8'h81);
    wr(12'h03A, 8'hC1);
    rd(12'h03B, 8'h80, 8'h80);
    anc = cyc + 10;
    fire_at(anc, 1);
    idle();
    rd(12'h03C, 8'h00, 8'h0F);
    rd(12'h03B, 8'h01, 8'h81);
    rd(12'h03A, 8'h00, 8'h40);
    wr(12'h03A, 8'hA1);
    rd(12'h03B, 8'h00, 8'h05);
    fire_at(anc + 2 * P + 3, 1);
    idle();
    rd(12'h03B, 8'h00, 8'h01);
    $display("one-shot test done");
    for (w = 0; w < 4; w++) begin
      s = $urandom_range(1, 3);
      if ($urandom_range(0, 1) == 1) s = -s;
      e = (s < 0) ? -s : s;
      bey = (w == 0) ? 1'b1 : (e > w);
      sd = bey ? ((s > 0) ? 8'h80 : 8'h40) : 8'h00;
      wr(12'h034, 8'(w));
      wr(12'h03A, 8'hE2);
      t = anc + P * ((cyc - anc) / P + 2) + s;
      fire_at(t, bey ? 2 : 1);
      idle();
      rd(12'h03B, {5'h00, bey, bey, 1'b1}, 8'h87);
      rd(12'h03C, bey ? 8'h00 : 8'(e), 8'h0F);
      rd(12'h03A, 8'h00, 8'h40);
      if (bey) begin
        rd(12'h038, 8'(e), 8'h0F);
        rd(12'h039, sd, 8'hC0);
        anc = t;
      end else begin
        rd(12'h03D, 8'h00, 8'hC0);
      end
    end
    $display("continuous test done");
    wr(12'h034, 8'h00);
    wr(12'h03A, 8'hA9);
    wr(12'h03A, 8'hC9);
    t = anc + P * ((cyc - anc) / P + 2) + 2;
    fire_at(t, 1);
    idle();
    anc = t;
    wr(12'h03A, 8'hA9);
    for (k = 0; k < 2; k++) begin
      fire_at(anc + P * ((cyc - anc) / P + 2) - 3, 1);
      idle();
      rd(12'h03B, 8'h03, 8'h87);
      rd(12'h03C, 8'h03, 8'h0F);
      rd(12'h03D, 8'h40, 8'hC0);
    end
    $display("monitor test done");
    wr(12'h021, 8'h01);
    cmp1(irq_o, 1'b1);
    wr(12'h025, 8'h0F);
    cmp1(irq_o, 1'b0);
    wr(12'h022, 8'h01);
    cmp1(irq_o, 1'b1);
    wr(12'h026, 8'h0F);
    cmp1(irq_o, 1'b0);
    fire_at(cyc + 5, 1);
    idle();
    cmp1(irq_o, 1'b1);
    rd(12'h025, 8'h01, 8'h01);
    $display("interrupt test done");
    // mode and clear land while edges still come only from the pin
    wr(12'h03A, 8'hA2);
    wr(12'h301, 8'h00);
    wr(12'h458, 8'h00);
    fire_at(cyc + 5, 1);
    idle();
    rd(12'h03B, 8'h00, 8'h05);
    wr(12'h03A, 8'hC1);
    idle();
    rd(12'h03B, 8'h01, 8'h81);
    $display("subclass zero test done");
    summarize();
  end
endmodule // lss_sync_tb_top
`default_nettype wire
